// [src/tf_pkg.sv]
// tape formatter package: register map, field layout, codes, timing
// assumes a 125 MHz core clock; tape speeds given in tenths of ips
package tf_pkg;
  localparam int unsigned CORE_CLK_NS = 8;
  localparam longint CORE_HZ = 64'd1000000000 / CORE_CLK_NS;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_CONF = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam int CMD_W = 9;
  localparam int MODE_W = 5;
  localparam int CONF_W = 7;
  localparam logic [6:0] CONF_RESET = 7'h01;
  // tape distance, in hundredths of an inch, paced by the speed clock
  localparam int unsigned TICKS_PER_INCH = 100;
  localparam logic [9:0] DLY_PRE1 = 10'h032;
  localparam logic [9:0] DLY_PRE2 = 10'h12C;
  localparam logic [9:0] DLY_POST = 10'h028;
  localparam logic [9:0] DLY_HALT = 10'h014;
  localparam logic [9:0] DLY_GAP_HI = 10'h01E;
  localparam logic [9:0] DLY_GAP_LO = 10'h03C;
  localparam int unsigned BPI_800 = 800;
  localparam int unsigned BPI_556 = 556;
  localparam int unsigned BPI_200 = 200;
  localparam logic [8:0] FM_NINE = 9'h013;
  localparam logic [8:0] FM_SEVEN = 9'h00F;
  localparam logic [8:0] CRC_POLY = 9'h13C;
  localparam logic [8:0] CRC_FINAL = 9'h1EB;

  typedef struct packed {
    logic read;
    logic write;
    logic fwd_space;
    logic rev_space;
    logic fmark;
    logic gap;
    logic ret;
    logic offline;
    logic clear;
  } tf_cmd_t;

  typedef struct packed {
    logic odd_par;
    logic hi_dens;
    logic edit;
    logic diag;
    logic multi;
  } tf_mode_t;

  typedef struct packed {
    logic nine;
    logic dual;
    logic special_fm;
    logic low_pair;
    logic [2:0] speed;
  } tf_conf_t;

  typedef enum logic [2:0] {
    ST_REST, ST_PRE1, ST_PRE2, ST_EXEC, ST_POST, ST_HALT_FWD,
    ST_HALT_REV, ST_REWIND
  } tf_state_t;

  typedef enum logic [2:0] {
    WP_IDLE, WP_DATA, WP_FM, WP_CRC, WP_LRC, WP_DONE
  } tf_wph_t;

  function automatic int unsigned tf_ips10(input logic [2:0] sel);
    case (sel)
      3'h0: return 125;
      3'h1: return 250;
      3'h2: return 375;
      3'h3: return 450;
      default: return 750;
    endcase
  endfunction

  // cycles per tape unit at a speed; a period rounds down
  function automatic logic [19:0] tf_period(input longint hz,
      input int unsigned ips10, input int unsigned per_inch);
    longint p;
    p = (hz * 10) / (longint'(ips10) * longint'(per_inch));
    if (p < 1) p = 1;
    return 20'(p);
  endfunction
endpackage

// [src/tf_formatter.sv]
// tape formatter: write framing, clocks, delays, gap detect, commands
// assumes strobed register port on core_clk; tape pins are asynchronous
//
// How it works
// R1: write bus carries data, file mark or check
// R2: file mark chosen by track count and special_fm, one clock
// R3: nine track: check char then longitudinal char
// R4: check char written raw, parity untouched
// R5: data flag pulsed per character until halt
// R6: halt appends checks then erases gap
// R7: single stack: post delay after longitudinal char
// R8: dual stack: post delay only on gap
// R9: upper char select alternates odd/even characters
// R10: write clock from speed and density
// R11: speed clock from tape speed only
// R12: density selectable on seven track only
// R13: ack clears flag, latches data; halt stops flags
// R14: delay counter stops at state-chosen count
// R15: read strobes reset counter; gap ends execute
// R16: eight basic commands on own lines
// R17: space one or many; reverse stops at load
// R18: gap erase alone or before writes
// R19: rewind stays busy until load point
// R20: offline never busy, sent while rewinding
// R21: parity and density lines ignored on nine
// R22: legal command and mode combinations honoured
// R23: post delay erases gap after written record
// R24: character requested a full period ahead
// R25: check char uses customary nine track polynomial
`timescale 1ns/1ns
module tf_formatter #(
  parameter longint CORE_HZ = tf_pkg::CORE_HZ
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_we, // write strobe
  input wire logic reg_re, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  output logic data_flag, // character request or ready
  input wire logic xfer_ack, // adapter acknowledge
  input wire logic xfer_halt, // adapter halt
  input wire logic space_stop, // adapter ends multi-record space
  input wire logic [7:0] wr_char, // write character from adapter
  output logic upper_char_select, // odd/even character marker
  input wire logic read_strobe_pin, // tape read strobe
  input wire logic load_point_pin, // tape at load point
  input wire logic rewinding_pin, // unit busy rewinding
  output logic [8:0] write_bus, // parity and character to tape
  output logic write_clock, // one write per pulse
  output logic unit_go, // tape motion
  output logic unit_reverse, // reverse direction
  output logic unit_write_en, // write and erase enable
  output logic unit_high_density, // density to unit
  output logic unit_return, // rewind pulse
  output logic unit_offline, // offline pulse
  output logic busy // formatter busy
);
  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic rs_meta_q, rs_sync_q, rs_prev_q;
  logic lp_meta_q, lp_sync_q, rw_meta_q, rw_sync_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {rs_meta_q, rs_sync_q, rs_prev_q} <= 3'h0;
      {lp_meta_q, lp_sync_q, rw_meta_q, rw_sync_q} <= 4'h0;
    end else begin
      rs_meta_q <= read_strobe_pin;
      rs_sync_q <= rs_meta_q;
      rs_prev_q <= rs_sync_q;
      lp_meta_q <= load_point_pin;
      lp_sync_q <= lp_meta_q;
      rw_meta_q <= rewinding_pin;
      rw_sync_q <= rw_meta_q;
    end
  end
  wire rstrobe_w = rs_sync_q & ~rs_prev_q;

  ////////////////////////////////////////////////////////////////////
  // register port
  tf_pkg::tf_cmd_t cmd_q, cmd_d;
  tf_pkg::tf_mode_t mode_q;
  tf_pkg::tf_conf_t conf_q;
  tf_pkg::tf_state_t st_q, st_d;
  tf_pkg::tf_wph_t wph_q, wph_d;
  logic halt_seen_q, flag_q, ucs_q, have_q, seen_rs_q;
  logic [7:0] char_q;
  logic [8:0] crc_q, lrc_q, wbus_q;
  logic wclk_q, ret_q, off_q;
  logic [9:0] dly_q;
  logic [19:0] wdiv_q, sdiv_q;
  logic [31:0] rdata_q;

  wire sel_cmd = reg_addr == tf_pkg::ADDR_CMD;
  wire sel_mode = reg_addr == tf_pkg::ADDR_MODE;
  wire sel_conf = reg_addr == tf_pkg::ADDR_CONF;
  wire sel_stat = reg_addr == tf_pkg::ADDR_STAT;
  wire tf_pkg::tf_cmd_t new_cmd = reg_wdata[tf_pkg::CMD_W-1:0];
  wire in_rest = st_q == tf_pkg::ST_REST;
  wire launch = reg_we & sel_cmd;
  // motion commands only from rest; offline and clear at any time
  wire motion_cmd = new_cmd.read | new_cmd.write | new_cmd.fwd_space |
                    new_cmd.rev_space | new_cmd.fmark | new_cmd.gap; // [R16]
  wire start_motion = launch & in_rest & motion_cmd & ~new_cmd.clear; // [R22]
  wire start_return = launch & (new_cmd.clear | (in_rest & new_cmd.ret));
  wire start_offline = launch & new_cmd.offline; // [R20]
  wire [31:0] stat_w = {20'h0, ucs_q, halt_seen_q, flag_q, lp_sync_q,
                        rw_sync_q, busy, 3'(st_q), 3'h0};
  wire [31:0] rd_mux = sel_cmd ? {23'h0, cmd_q} :
                       sel_mode ? {27'h0, mode_q} :
                       sel_conf ? {25'h0, conf_q} :
                       sel_stat ? stat_w : 32'h0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= '0;
      conf_q <= tf_pkg::CONF_RESET;
      rdata_q <= 32'h0;
    end else begin
      if (reg_we & sel_mode) mode_q <= reg_wdata[tf_pkg::MODE_W-1:0];
      if (reg_we & sel_conf & in_rest)
        conf_q <= reg_wdata[tf_pkg::CONF_W-1:0];
      rdata_q <= reg_re ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clocks: speed clock from speed, write clock from speed and density
  wire [31:0] ips10_w = tf_pkg::tf_ips10(conf_q.speed); // [R11]
  // seven track: pair 800/556 or 556/200; nine track fixed at 800
  wire seven_hi = mode_q.hi_dens & ~conf_q.nine; // [R12] [R21]
  wire [31:0] bpi_w = conf_q.nine ? tf_pkg::BPI_800 :
                      conf_q.low_pair ?
                        (seven_hi ? tf_pkg::BPI_556 : tf_pkg::BPI_200) :
                        (seven_hi ? tf_pkg::BPI_800 : tf_pkg::BPI_556);
  wire [19:0] wper_w = tf_pkg::tf_period(CORE_HZ, ips10_w, bpi_w); // [R10]
  wire [19:0] sper_w = tf_pkg::tf_period(CORE_HZ, ips10_w,
                                         tf_pkg::TICKS_PER_INCH);
  wire stick_w = sdiv_q >= sper_w - 20'h1;
  wire in_exec = st_q == tf_pkg::ST_EXEC;
  wire wtick_w = in_exec & (wdiv_q >= wper_w - 20'h1);
  wire st_change = st_d != st_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sdiv_q <= 20'h0;
      wdiv_q <= 20'h0;
    end else begin
      sdiv_q <= stick_w ? 20'h0 : sdiv_q + 20'h1;
      // restart at execute entry so the first request has a full period
      wdiv_q <= (wtick_w | st_change) ? 20'h0 : wdiv_q + 20'h1; // [R24]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // delay counter and gap detector
  wire is_write = cmd_q.write | cmd_q.fmark;
  wire gap_lim_lo = ~conf_q.nine & ~mode_q.hi_dens; // [R21]
  wire [9:0] lim_w =
      (st_q == tf_pkg::ST_PRE1) ? tf_pkg::DLY_PRE1 :
      (st_q == tf_pkg::ST_PRE2) ? tf_pkg::DLY_PRE2 :
      (st_q == tf_pkg::ST_POST) ? tf_pkg::DLY_POST :
      (st_q == tf_pkg::ST_EXEC) ?
        (gap_lim_lo ? tf_pkg::DLY_GAP_LO : tf_pkg::DLY_GAP_HI) :
      tf_pkg::DLY_HALT; // [R14]
  wire stop_w = dly_q >= lim_w; // [R14]
  // gap armed once the record has started to pass the read head
  wire gap_w = in_exec & seen_rs_q & stop_w & ~rstrobe_w; // [R15]

  always_ff @(posedge core_clk) begin
    if (rst) dly_q <= 10'h0;
    else if (st_change | start_return | rstrobe_w) dly_q <= 10'h0; // [R15]
    else if (stick_w & ~stop_w) dly_q <= dly_q + 10'h1; // [R14]
  end

  ////////////////////////////////////////////////////////////////////
  // character formation and check characters
  wire [7:0] data8 = conf_q.nine ? char_q : {2'h0, char_q[5:0]};
  // nine track always odd; seven track follows the parity line
  wire par_w = conf_q.nine ? ~(^char_q) : (^char_q[5:0]) ^ mode_q.odd_par;
  wire [8:0] data_char = {par_w, data8};
  wire [8:0] fm_char = (conf_q.nine & ~conf_q.special_fm) ?
                       tf_pkg::FM_NINE : tf_pkg::FM_SEVEN; // [R2]
  wire [8:0] crc_mix = crc_q ^ data_char;
  wire [8:0] crc_rot = {crc_mix[7:0], crc_mix[8]};
  wire [8:0] crc_next = crc_mix[8] ? (crc_rot ^ tf_pkg::CRC_POLY) :
                        crc_rot; // [R25]
  wire [8:0] crc_char_w = crc_q ^ tf_pkg::CRC_FINAL; // [R4]
  wire wr_data = wtick_w & (wph_q == tf_pkg::WP_DATA) & ~halt_seen_q &
                 have_q;
  wire wr_crc = wtick_w & (wph_q == tf_pkg::WP_CRC);
  wire wr_lrc = wtick_w & (wph_q == tf_pkg::WP_LRC);
  wire wr_fm = wtick_w & (wph_q == tf_pkg::WP_FM);
  // exactly one source reaches the bus at each write clock
  wire [8:0] bus_sel = wr_fm ? fm_char :
                       wr_crc ? crc_char_w :
                       wr_lrc ? lrc_q : data_char; // [R1]
  wire wr_any = wr_data | wr_crc | wr_lrc | wr_fm;

  ////////////////////////////////////////////////////////////////////
  // write phase
  always_comb begin
    wph_d = wph_q;
    if (st_change & (st_d == tf_pkg::ST_EXEC))
      wph_d = cmd_q.write ? tf_pkg::WP_DATA :
              cmd_q.fmark ? tf_pkg::WP_FM :
              cmd_q.gap ? tf_pkg::WP_DONE : tf_pkg::WP_IDLE; // [R18]
    else if (~in_exec)
      wph_d = tf_pkg::WP_IDLE;
    else if (wtick_w) begin
      unique case (wph_q)
        tf_pkg::WP_DATA:
          if (halt_seen_q)
            wph_d = conf_q.nine ? tf_pkg::WP_CRC : tf_pkg::WP_LRC; // [R6]
        tf_pkg::WP_CRC: wph_d = tf_pkg::WP_LRC; // [R3]
        tf_pkg::WP_LRC: wph_d = tf_pkg::WP_DONE;
        tf_pkg::WP_FM: wph_d = tf_pkg::WP_DONE; // [R2]
        tf_pkg::WP_IDLE, tf_pkg::WP_DONE: wph_d = wph_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // formatter state
  wire at_lp = lp_sync_q;
  wire long_pre = new_cmd.gap | ((new_cmd.write | new_cmd.fmark) & at_lp);
  wire more_space = (cmd_q.fwd_space | cmd_q.rev_space) & mode_q.multi &
                    ~space_stop; // [R17]
  wire wr_end = is_write | cmd_q.gap;
  wire exec_done = wr_end ?
      (cmd_q.gap & ~is_write ? wph_q == tf_pkg::WP_DONE :
       conf_q.dual ? (gap_w & wph_q == tf_pkg::WP_DONE) : // [R8]
       wph_q == tf_pkg::WP_DONE) : // [R7]
      (gap_w & ~more_space); // [R15]
  always_comb begin
    st_d = st_q;
    if (start_return) st_d = tf_pkg::ST_REWIND; // [R19]
    else begin
      unique case (st_q)
        tf_pkg::ST_REST:
          if (start_motion)
            st_d = long_pre ? tf_pkg::ST_PRE2 : tf_pkg::ST_PRE1; // [R18]
        tf_pkg::ST_PRE1, tf_pkg::ST_PRE2:
          if (stop_w) st_d = tf_pkg::ST_EXEC;
        tf_pkg::ST_EXEC:
          if (cmd_q.rev_space & at_lp) st_d = tf_pkg::ST_HALT_REV; // [R17]
          else if (exec_done) st_d = tf_pkg::ST_POST; // [R23]
        tf_pkg::ST_POST:
          if (stop_w)
            st_d = cmd_q.rev_space ? tf_pkg::ST_HALT_REV :
                   tf_pkg::ST_HALT_FWD;
        tf_pkg::ST_HALT_FWD, tf_pkg::ST_HALT_REV:
          if (stop_w) st_d = tf_pkg::ST_REST;
        tf_pkg::ST_REWIND:
          // hold off until the unit has had time to report rewinding
          if (at_lp & ~rw_sync_q & stop_w) st_d = tf_pkg::ST_REST; // [R19]
      endcase
    end
  end
  assign cmd_d = start_motion ? new_cmd : cmd_q;

  ////////////////////////////////////////////////////////////////////
  // handshake, check accumulators, outputs
  wire exec_entry = st_change & (st_d == tf_pkg::ST_EXEC);
  wire want_char = exec_entry ? (cmd_q.write & ~mode_q.diag) :
                   wr_data; // [R5] [R24]
  wire read_flag = in_exec & cmd_q.read & rstrobe_w & ~halt_seen_q &
                   ~xfer_halt; // [R13]
  wire flag_set = (want_char & ~halt_seen_q & ~xfer_halt) | read_flag;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= tf_pkg::ST_REST;
      wph_q <= tf_pkg::WP_IDLE;
      cmd_q <= '0;
      {halt_seen_q, flag_q, ucs_q, have_q, seen_rs_q} <= 5'h0;
      char_q <= 8'h0;
      {crc_q, lrc_q, wbus_q} <= 27'h0;
      {wclk_q, ret_q, off_q} <= 3'h0;
    end else begin
      st_q <= st_d;
      wph_q <= wph_d;
      cmd_q <= cmd_d;
      // set wins over a same-cycle acknowledge
      flag_q <= flag_set | (flag_q & ~xfer_ack & ~exec_entry); // [R13]
      if (exec_entry) halt_seen_q <= 1'b0;
      else if (in_exec & xfer_halt) halt_seen_q <= 1'b1; // [R13]
      if (exec_entry) seen_rs_q <= 1'b0;
      else if (rstrobe_w) seen_rs_q <= 1'b1;
      else if (gap_w) seen_rs_q <= 1'b0;
      if (xfer_ack & flag_q & is_write) begin
        char_q <= wr_char; // [R13]
        have_q <= 1'b1;
      end else if (wr_data | exec_entry) have_q <= 1'b0;
      if (exec_entry) ucs_q <= 1'b0;
      else if (wr_data) ucs_q <= ~ucs_q; // [R9]
      if (exec_entry) begin
        crc_q <= 9'h0;
        lrc_q <= 9'h0;
      end else begin
        if (wr_data) crc_q <= crc_next; // [R25]
        if (wr_data | wr_crc) lrc_q <= lrc_q ^ bus_sel;
      end
      wclk_q <= wr_any; // [R1]
      if (wr_any) wbus_q <= bus_sel;
      ret_q <= start_return & new_cmd.ret;
      off_q <= start_offline; // [R20]
    end
  end

  logic go_q, rev_q, wen_q, hd_q, busy_q;
  always_ff @(posedge core_clk) begin
    if (rst) {go_q, rev_q, wen_q, hd_q, busy_q} <= 5'h0;
    else begin
      go_q <= (st_d != tf_pkg::ST_REST) & (st_d != tf_pkg::ST_REWIND) &
              (st_d != tf_pkg::ST_HALT_FWD) & (st_d != tf_pkg::ST_HALT_REV);
      rev_q <= cmd_d.rev_space;
      wen_q <= (cmd_d.write | cmd_d.fmark | cmd_d.gap) & ~rev_q &
               (st_d inside {tf_pkg::ST_PRE1, tf_pkg::ST_PRE2,
                             tf_pkg::ST_EXEC, tf_pkg::ST_POST}); // [R23]
      hd_q <= seven_hi; // [R12]
      busy_q <= st_d != tf_pkg::ST_REST; // [R19]
    end
  end

  assign reg_rdata = rdata_q;
  assign data_flag = flag_q;
  assign upper_char_select = ucs_q;
  assign write_bus = wbus_q;
  assign write_clock = wclk_q;
  assign unit_go = go_q;
  assign unit_reverse = rev_q;
  assign unit_write_en = wen_q;
  assign unit_high_density = hd_q;
  assign unit_return = ret_q;
  assign unit_offline = off_q;
  assign busy = busy_q;

  ////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_ONE_SOURCE: assert property ( // [R1]
    wr_any |=> write_clock && $onehot({$past(wr_fm), $past(wr_crc),
      $past(wr_lrc), $past(wr_data)}))
    else $error("write clock without a single source");
  AST_FM_CODE: assert property ( // [R2]
    wr_fm |=> write_clock && write_bus == $past(fm_char))
    else $error("file mark code not written");
  AST_CRC_WRITE: assert property ( // [R3]
    wr_crc |=> write_clock && write_bus == $past(crc_char_w) &&
      wph_q == tf_pkg::WP_LRC)
    else $error("check character not written before lrc");
  AST_FLAG_ACK: assert property ( // [R13]
    flag_q && xfer_ack && !flag_set && !exec_entry |=> !data_flag)
    else $error("acknowledge did not clear flag");
  AST_HALT_NO_FLAG: assert property ( // [R13]
    in_exec && halt_seen_q && !data_flag && !exec_entry |=> !data_flag)
    else $error("flag raised after halt");
  AST_SINGLE_POST: assert property ( // [R7]
    in_exec && is_write && !conf_q.dual && wph_q == tf_pkg::WP_DONE &&
      !start_return && !(cmd_q.rev_space && at_lp) |=>
      st_q == tf_pkg::ST_POST)
    else $error("single stack write did not enter post delay");
  AST_DUAL_WAIT: assert property ( // [R8]
    in_exec && is_write && conf_q.dual && !gap_w && !start_return |=>
      st_q == tf_pkg::ST_EXEC)
    else $error("dual stack write left execute without gap");
  AST_GAP_RESET: assert property ( // [R15]
    rstrobe_w |=> dly_q == 10'h0)
    else $error("read strobe did not reset delay counter");
  AST_OFFLINE_IDLE: assert property ( // [R20]
    in_rest && launch && new_cmd == tf_pkg::tf_cmd_t'(9'h002) |=>
      unit_offline ##1 !busy)
    else $error("offline made the formatter busy");
  AST_REWIND_BUSY: assert property ( // [R19]
    start_return |=> st_q == tf_pkg::ST_REWIND ##1 busy)
    else $error("rewind did not hold busy");
  AST_BOT_REV: assert property ( // [R17]
    in_exec && cmd_q.rev_space && at_lp && !start_return |=>
      st_q == tf_pkg::ST_HALT_REV)
    else $error("reverse space passed load point");

  COV_WRITE_REC: cover property (wr_lrc ##1 write_clock);
  COV_FILE_MARK: cover property (wr_fm);
  COV_GAP_END: cover property (gap_w ##1 st_q == tf_pkg::ST_POST);
  COV_REWIND: cover property (st_q == tf_pkg::ST_REWIND ##1 in_rest);
endmodule

// [tb/tf_partner.sv]
// adapter handshake and tape unit model facing the formatter
// assumes formatter outputs are registered on core_clk
`timescale 1ns/1ns
module tf_partner (
  input wire logic core_clk, // core clock
  input wire logic rst, // reset
  input wire logic [3:0] ack_dly, // cycles before ack
  input wire logic data_flag, // character request
  input wire logic unit_go, // tape motion
  input wire logic unit_reverse, // reverse motion
  input wire logic unit_return, // rewind pulse
  output logic xfer_ack = 1'b0, // ack pulse
  output logic [7:0] wr_char = 8'h00, // character with ack
  output logic read_strobe_pin = 1'b0, // read strobe
  output logic load_point_pin = 1'b0, // at load point
  output logic rewinding_pin = 1'b0 // rewinding
);
  logic [3:0] wait_q;
  logic [7:0] next_q;
  logic [9:0] rw_q;
  logic [7:0] rs_q;
  logic [11:0] lead_q;
  always @(posedge core_clk) begin
    xfer_ack <= 1'b0;
    wr_char <= ~wr_char;
    read_strobe_pin <= (rs_q != 8'h00) && rs_q[2];
    if (rst) begin
      wait_q <= 4'h0;
      next_q <= 8'h3A;
      rw_q <= 10'h000;
      rs_q <= 8'h00;
      lead_q <= 12'h000;
    end else begin
      // one ack per flag, char held with it
      if (data_flag && !xfer_ack) begin
        if (wait_q == ack_dly) begin
          xfer_ack <= 1'b1;
          wr_char <= next_q;
          next_q <= next_q + 8'h01;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
      // records pass the head while moving, none past load point
      lead_q <= unit_go ? lead_q + 12'h001 : 12'h000;
      if (unit_go && lead_q == 12'hC00 &&
          !(unit_reverse && load_point_pin)) begin
        rs_q <= 8'h80;
      end else if (rs_q != 8'h00) begin
        rs_q <= rs_q - 8'h01;
      end
      if (unit_return) begin
        rw_q <= 10'h12C;
        rewinding_pin <= 1'b1;
      end else if (rw_q == 10'h001) begin
        rw_q <= 10'h000;
        rewinding_pin <= 1'b0;
        load_point_pin <= 1'b1;
      end else if (rw_q != 10'h000) begin
        rw_q <= rw_q - 10'h001;
      end else if (unit_go && !unit_reverse) begin
        load_point_pin <= 1'b0;
      end
    end
  end
endmodule

// [tb/tf_formatter_test.sv]
// self-checking bench for the tape formatter
// assumes tf_partner as adapter and tape unit, shortened core rate
`timescale 1ns/1ns
module tf_formatter_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic xfer_halt = 1'b0;
  logic space_stop = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [31:0] reg_rdata;
  logic [7:0] wr_char;
  logic [8:0] write_bus;
  logic data_flag, xfer_ack, upper_char_select, read_strobe_pin;
  logic load_point_pin, rewinding_pin, write_clock, unit_go;
  logic unit_reverse, unit_write_en, unit_high_density;
  logic unit_return, unit_offline, busy;
  int n_errors = 0;
  int num_checks = 0;
  int n_ret = 0;
  int n_off = 0;
  logic [8:0] wq[$];
  logic uq[$];
  always #4 core_clk = ~core_clk;
  tf_formatter #(.CORE_HZ(125000)) dut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .data_flag(data_flag),
    .xfer_ack(xfer_ack), .xfer_halt(xfer_halt), .space_stop(space_stop),
    .wr_char(wr_char), .upper_char_select(upper_char_select),
    .read_strobe_pin(read_strobe_pin), .load_point_pin(load_point_pin),
    .rewinding_pin(rewinding_pin), .write_bus(write_bus),
    .write_clock(write_clock), .unit_go(unit_go),
    .unit_reverse(unit_reverse), .unit_write_en(unit_write_en),
    .unit_high_density(unit_high_density), .unit_return(unit_return),
    .unit_offline(unit_offline), .busy(busy));
  tf_partner far (.core_clk(core_clk), .rst(rst), .ack_dly(ack_dly),
    .data_flag(data_flag), .unit_go(unit_go), .unit_reverse(unit_reverse),
    .unit_return(unit_return), .xfer_ack(xfer_ack), .wr_char(wr_char),
    .read_strobe_pin(read_strobe_pin), .load_point_pin(load_point_pin),
    .rewinding_pin(rewinding_pin));
  always @(posedge core_clk) begin
    if (write_clock === 1'b1) begin
      wq.push_back(write_bus);
      uq.push_back(upper_char_select);
    end
    if (unit_return === 1'b1) n_ret++;
    if (unit_offline === 1'b1) n_off++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    repeat (2) @(negedge core_clk);
    while (busy !== 1'b0 && i < 20000) begin
      @(negedge core_clk);
      i++;
    end
    chk("busy idle", 32'h0, {31'h0, busy});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    rd(tf_pkg::ADDR_CONF, d);
    chk("conf reset", 32'h01, d);
    rd(8'h10, d);
    chk("unmapped", 32'h0, d);
    wr(tf_pkg::ADDR_MODE, 32'h08);
    repeat (3) @(negedge core_clk);
    chk("density seven", 32'h1, {31'h0, unit_high_density});
    wr(tf_pkg::ADDR_CONF, 32'h41);
    repeat (3) @(negedge core_clk);
    chk("density nine", 32'h0, {31'h0, unit_high_density});
  endtask
  task automatic t_write9;
    int n;
    logic [8:0] longitudinal_check_char;
    logic [8:0] crc, mix;
    logic [7:0] c;
    wq.delete();
    uq.delete();
    ack_dly <= 4'h4;
    wr(tf_pkg::ADDR_MODE, 32'h0);
    wr(tf_pkg::ADDR_CMD, 32'h80);
    n = 0;
    while (wq.size() < 6 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    chk("write enable", 32'h1, {31'h0, unit_write_en});
    @(posedge core_clk);
    xfer_halt <= 1'b1;
    wait_idle();
    @(posedge core_clk);
    xfer_halt <= 1'b0;
    n = wq.size();
    chk("write count", 32'h1, {31'h0, n >= 8});
    longitudinal_check_char = 9'h000;
    crc = 9'h000;
    for (int i = 0; i < n - 1; i++) begin
      c = 8'h3A + 8'(i);
      if (i < n - 2) begin
        chk("data char", {23'h0, ~^c, c}, {23'h0, wq[i]});
        chk("upper select", {31'h0, ~i[0]}, {31'h0, uq[i]});
        mix = crc ^ {~^c, c};
        crc = {mix[7:0], mix[8]} ^ (mix[8] ? tf_pkg::CRC_POLY : 9'h000);
      end
      longitudinal_check_char = longitudinal_check_char ^ wq[i];
    end
    crc = crc ^ tf_pkg::CRC_FINAL;
    if (n > 2) chk("cyclic char", {23'h0, crc}, {23'h0, wq[n-2]});
    if (n > 1) chk("check chars", {23'h0, longitudinal_check_char}, {23'h0, wq[n-1]});
  endtask
  task automatic t_fmark;
    logic [6:0] cf[3];
    logic [8:0] fm[3];
    cf = '{7'h41, 7'h01, 7'h51};
    fm = '{tf_pkg::FM_NINE, tf_pkg::FM_SEVEN, tf_pkg::FM_SEVEN};
    ack_dly <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      wq.delete();
      wr(tf_pkg::ADDR_CONF, {25'h0, cf[i]});
      wr(tf_pkg::ADDR_CMD, 32'h10);
      wait_idle();
      chk("file mark", {23'h0, fm[i]},
        {23'h0, wq.size() > 0 ? wq[0] : 9'h1FF});
    end
  endtask
  task automatic t_space;
    logic [31:0] d;
    wr(tf_pkg::ADDR_CONF, 32'h01);
    wr(tf_pkg::ADDR_CMD, 32'h40);
    repeat (200) @(negedge core_clk);
    chk("space busy", 32'h1, {31'h0, busy});
    chk("space motion", 32'h2, {30'h0, unit_go, unit_write_en});
    wait_idle();
    wr(tf_pkg::ADDR_MODE, 32'h01);
    wr(tf_pkg::ADDR_CMD, 32'h40);
    repeat (7000) @(negedge core_clk);
    rd(tf_pkg::ADDR_STAT, d);
    chk("multi space state", 32'h3, {29'h0, d[5:3]});
    @(posedge core_clk);
    space_stop <= 1'b1;
    wait_idle();
  endtask
  task automatic t_rewind;
    logic [31:0] d;
    wr(tf_pkg::ADDR_CMD, 32'h02);
    repeat (4) @(negedge core_clk);
    chk("offline pulse", 32'h1, n_off);
    chk("offline busy", 32'h0, {31'h0, busy});
    wr(tf_pkg::ADDR_CMD, 32'h04);
    repeat (4) @(negedge core_clk);
    chk("return pulse", 32'h1, n_ret);
    chk("rewind busy", 32'h1, {31'h0, busy});
    wr(tf_pkg::ADDR_CMD, 32'h02);
    repeat (4) @(negedge core_clk);
    chk("offline rewinding", 32'h2, n_off);
    wait_idle();
    rd(tf_pkg::ADDR_STAT, d);
    chk("load point", 32'h1, {31'h0, d[8]});
    wr(tf_pkg::ADDR_CMD, 32'h20);
    repeat (4) @(negedge core_clk);
    chk("reverse", 32'h1, {31'h0, unit_reverse});
    wait_idle();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (80000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_write9();
    t_fmark();
    t_space();
    t_rewind();
    end_sim();
  end
endmodule
